// [rtl/acs_pkg.sv]
package acs_pkg;
    // clock rate and documented times
    localparam int CLK_MHZ = 50;
    localparam int T_START_US = 800;
    localparam int T_WAKE_US = 450;
    localparam int T_SCLTO_MS = 35;
    localparam int US_PER_MS = 1000;
    // longest times round down, least time rounds up (all exact here)
    localparam int START_CYC = T_START_US * CLK_MHZ;
    localparam int WAKE_CYC = T_WAKE_US * CLK_MHZ;
    localparam int SCLTO_CYC = T_SCLTO_MS * US_PER_MS * CLK_MHZ;
    // core clocks per sampling clock period
    localparam int FS_DIV = 200;
    localparam int TMR_W = 21;
    localparam int LEN_W = 14;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CONV = 8'h04;
    localparam logic [7:0] OFS_BIAS = 8'h08;
    localparam logic [7:0] OFS_ACFG1 = 8'h0c;
    localparam logic [7:0] OFS_ACFG5 = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_LAST_LEN = 8'h2c;

    // control register bits
    localparam int CTRL_START = 0;
    localparam int CTRL_CONT = 1;
    localparam int CTRL_BYPASS = 2;
    localparam int CTRL_TO_EN = 3;
    localparam int CTRL_SOFT_RST = 4;
    localparam int CTRL_SLEEP = 5;

    // conversion config fields
    localparam int CONV_OSR_LSB = 0;
    localparam int CONV_NEL_LSB = 4;
    localparam logic [3:0] OSR_LOG2_MIN = 4'h3;
    localparam logic [3:0] OSR_LOG2_MAX = 4'ha;
    localparam logic [3:0] OSR_LOG2_RST = 4'h3;
    localparam logic [3:0] NEL_RST = 4'h1;

    // bias fields and reset (full bias)
    localparam int BIAS_AMP_LSB = 0;
    localparam int BIAS_ADC_LSB = 2;
    localparam logic [1:0] BIAS_RST = 2'h3;

    // status bits
    localparam int ST_BUSY = 0;
    localparam int ST_STARTED = 1;
    localparam int ST_OSC = 2;
    localparam int ST_SETTLED = 3;
    localparam int ST_RES_LSB = 8;

    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_CONV = 0;
    localparam int IRQ_SCLTO = 1;
    localparam int IRQ_STARTED = 2;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/acs_delay.sv]
`timescale 1ns/1ps
// elapsed-time counter: restarts from zero, saturates at limit
module acs_delay #(
    parameter int W = 21
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // control
    input wire logic restart,
    input wire logic [W-1:0] limit,
    // status
    output logic expired
);
    logic [W-1:0] cnt; // cycles since restart

    // count up until the limit is reached
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= '0;
        end
        else if (restart)
        begin
            cnt <= '0;
        end
        else if (cnt < limit)
        begin
            cnt <= cnt + W'(1);
        end
    end

    // expired once limit cycles have passed without restart
    assign expired = (cnt >= limit) && !restart;
endmodule

// [rtl/acs_sequencer.sv]
`timescale 1ns/1ps
module acs_sequencer #(
    parameter int START_CYCLES = acs_pkg::START_CYC,
    parameter int WAKE_CYCLES = acs_pkg::WAKE_CYC,
    parameter int SCLTO_CYCLES = acs_pkg::SCLTO_CYC,
    parameter int FS_DIV = acs_pkg::FS_DIV
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // serial bus clock pin
    input wire logic scl_in,
    // analog and status outputs
    output logic ready,
    output logic pga_reset,
    output logic serial_if_rst,
    output logic osc_en,
    output logic [2:0] amplifier_bias_quarters,
    output logic [2:0] converter_bias_quarters,
    output logic irq
);
    typedef enum logic [0:0] {ACS_IDLE, ACS_RUN} acs_state_t;

    // bus holding state
    logic aw_full; // write address held
    logic w_full; // write data held
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic w_lo; // low byte lane enabled
    logic wr_go; // write performed this cycle
    logic wr_hit; // write address mapped
    logic [7:0] wa; // word-aligned write address
    logic [31:0] rd_mux;
    logic rd_hit;

    // software registers
    logic cont_mode;
    logic bypass;
    logic to_en;
    logic sleep;
    logic [3:0] osr_log2;
    logic [3:0] nel;
    logic [1:0] amplifier_bias_select;
    logic [1:0] converter_bias_select;
    logic [7:0] analog_config_registers [5];
    logic [acs_pkg::IRQ_W-1:0] irq_stat;
    logic [acs_pkg::IRQ_W-1:0] irq_mask;
    logic [acs_pkg::IRQ_W-1:0] irq_event;
    logic [acs_pkg::IRQ_W-1:0] irq_clr;

    // command pulses from writes
    logic start_req;
    logic soft_rst;
    logic acfg_wr;

    // timers and clocking
    logic started;
    logic started_q;
    logic osc_run;
    logic scl_meta;
    logic scl_s;
    logic scl_to;
    logic scl_to_q;
    logic [15:0] div_cnt;
    logic fs_tick;

    // conversion
    acs_state_t state;
    logic [acs_pkg::LEN_W-1:0] conv_len;
    logic [acs_pkg::LEN_W-1:0] conv_cnt;
    logic [acs_pkg::LEN_W-1:0] last_len;
    logic [10:0] settle_cnt;
    logic settled;
    logic conv_done;
    logic [4:0] resolution;
    logic [3:0] nel_log2;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign wr_go = aw_full && w_full && !s_axi_bvalid;
    assign wa = {aw_addr[7:2], 2'h0};
    assign wr_hit = (wa <= acs_pkg::OFS_LAST_LEN);

    // hold address and data until both are present
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_lo <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_full <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_lo <= s_axi_wstrb[0];
            end
            else if (wr_go)
                w_full <= 1'b0;
        end
    end

    // write response after the write is done
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= acs_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read decode
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        unique case ({s_axi_araddr[7:2], 2'h0})
            acs_pkg::OFS_CTRL: rd_mux = 32'({sleep, 1'b0, to_en, bypass, cont_mode, 1'b0});
            acs_pkg::OFS_CONV: rd_mux = 32'({nel, osr_log2});
            acs_pkg::OFS_BIAS: rd_mux = 32'({converter_bias_select, amplifier_bias_select});
            acs_pkg::OFS_STAT: rd_mux = 32'({resolution, 4'h0, settled, osc_run, started,
                                             state == ACS_RUN});
            acs_pkg::OFS_IRQ_STAT: rd_mux = 32'(irq_stat);
            acs_pkg::OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
            acs_pkg::OFS_LAST_LEN: rd_mux = 32'(last_len);
            // analog config block or unmapped
            default:
                if (s_axi_araddr >= acs_pkg::OFS_ACFG1 && s_axi_araddr <= acs_pkg::OFS_ACFG5 + 8'h3)
                    rd_mux = 32'(analog_config_registers[3'(s_axi_araddr[4:2] - 3'h3)]);
                else
                    rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read data one cycle after the address is taken
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= acs_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign start_req = wr_go && w_lo && wa == acs_pkg::OFS_CTRL && w_data[acs_pkg::CTRL_START];
    assign soft_rst = wr_go && w_lo && wa == acs_pkg::OFS_CTRL
                      && w_data[acs_pkg::CTRL_SOFT_RST];
    assign acfg_wr = wr_go && w_lo && wa >= acs_pkg::OFS_ACFG1 && wa <= acs_pkg::OFS_ACFG5;
    assign irq_clr = (wr_go && w_lo && wa == acs_pkg::OFS_IRQ_STAT)
                     ? w_data[acs_pkg::IRQ_W-1:0] : '0;

    // control, conversion and bias settings
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cont_mode <= 1'b0;
            bypass <= 1'b0;
            to_en <= 1'b1;
            sleep <= 1'b0;
            osr_log2 <= acs_pkg::OSR_LOG2_RST;
            nel <= acs_pkg::NEL_RST;
            amplifier_bias_select <= acs_pkg::BIAS_RST;
            converter_bias_select <= acs_pkg::BIAS_RST;
            irq_mask <= '0;
        end
        else if (soft_rst)
        begin
            // software reset restores cont_mode, to_en and sleep defaults
            cont_mode <= 1'b0;
            to_en <= 1'b1;
            sleep <= 1'b0;
        end
        else if (wr_go && w_lo)
        begin
            if (wa == acs_pkg::OFS_CTRL)
            begin
                cont_mode <= w_data[acs_pkg::CTRL_CONT];
                bypass <= w_data[acs_pkg::CTRL_BYPASS];
                to_en <= w_data[acs_pkg::CTRL_TO_EN];
                sleep <= w_data[acs_pkg::CTRL_SLEEP];
            end
            // any other bus write with the low byte lane enabled wakes the device
            else if (sleep)
                sleep <= 1'b0;
            if (wa == acs_pkg::OFS_CONV)
            begin
                // illegal ratio or count keeps old value
                if (w_data[acs_pkg::CONV_OSR_LSB +: 4] >= acs_pkg::OSR_LOG2_MIN
                    && w_data[acs_pkg::CONV_OSR_LSB +: 4] <= acs_pkg::OSR_LOG2_MAX)
                    osr_log2 <= w_data[acs_pkg::CONV_OSR_LSB +: 4];
                if ($onehot(w_data[acs_pkg::CONV_NEL_LSB +: 4]))
                    nel <= w_data[acs_pkg::CONV_NEL_LSB +: 4];
            end
            if (wa == acs_pkg::OFS_BIAS)
            begin
                amplifier_bias_select <= w_data[acs_pkg::BIAS_AMP_LSB +: 2];
                converter_bias_select <= w_data[acs_pkg::BIAS_ADC_LSB +: 2];
            end
            if (wa == acs_pkg::OFS_IRQ_MASK)
                irq_mask <= w_data[acs_pkg::IRQ_W-1:0];
        end
    end

    // analog configuration storage
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            for (int i = 0; i < 5; i++)
                analog_config_registers[i] <= 8'h0;
        else if (acfg_wr)
            analog_config_registers[3'(wa[4:2] - 3'h3)] <= w_data[7:0];
    end

    // amplifier reset pulse on every analog config write
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            pga_reset <= 1'b0;
        else
            pga_reset <= acfg_wr;
    end

    // bias code to quarters of full current
    assign amplifier_bias_quarters = {1'b0, amplifier_bias_select} + 3'h1;
    assign converter_bias_quarters = {1'b0, converter_bias_select} + 3'h1;

    acs_delay #(.W(acs_pkg::TMR_W)) u_start (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .restart(soft_rst),
        .limit(acs_pkg::TMR_W'(START_CYCLES)),
        .expired(started)
    );

    acs_delay #(.W(acs_pkg::TMR_W)) u_wake (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .restart(sleep),
        .limit(acs_pkg::TMR_W'(WAKE_CYCLES)),
        .expired(osc_run)
    );

    acs_delay #(.W(acs_pkg::TMR_W)) u_sclto (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .restart(scl_s || !to_en),
        .limit(acs_pkg::TMR_W'(SCLTO_CYCLES)),
        .expired(scl_to)
    );

    assign osc_en = !sleep;

    // pin synchroniser and edge memories
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_to_q <= 1'b0;
            started_q <= 1'b0;
            serial_if_rst <= 1'b0;
        end
        else
        begin
            scl_meta <= scl_in;
            scl_s <= scl_meta;
            scl_to_q <= scl_to;
            started_q <= started;
            serial_if_rst <= scl_to && !scl_to_q;
        end
    end

    // sampling clock divider, held at zero while osc_run is low
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt <= 16'h0;
        else if (!osc_run || fs_tick)
            div_cnt <= 16'h0;
        else
            div_cnt <= div_cnt + 16'h1;
    end

    assign fs_tick = osc_run && div_cnt == 16'(FS_DIV - 1);

    // log2 of the one-hot elementary count
    always_comb
    begin
        nel_log2 = 4'h0;
        for (int i = 0; i < 4; i++)
            if (nel[i])
                nel_log2 = 4'(i);
    end

    assign conv_len = acs_pkg::LEN_W'(nel) * ((acs_pkg::LEN_W'(1) << osr_log2)
                      + acs_pkg::LEN_W'(1)) + acs_pkg::LEN_W'(1);
    assign resolution = 5'({osr_log2, 1'b0}) + 5'(nel_log2);
    assign conv_done = state == ACS_RUN && fs_tick && conv_cnt == last_len - acs_pkg::LEN_W'(1);

    // conversion state and period counter
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ACS_IDLE;
            conv_cnt <= '0;
            last_len <= '0;
        end
        else if (soft_rst || !started)
        begin
            state <= ACS_IDLE;
            conv_cnt <= '0;
        end
        else
        begin
            unique case (state)
                // start only when running and awake
                ACS_IDLE:
                    if (start_req && osc_run)
                    begin
                        state <= ACS_RUN;
                        conv_cnt <= '0;
                        last_len <= conv_len;
                    end
                ACS_RUN:
                    if (conv_done)
                    begin
                        // continuous mode rearms at once
                        state <= cont_mode ? ACS_RUN : ACS_IDLE;
                        conv_cnt <= '0;
                        last_len <= conv_len;
                    end
                    else if (fs_tick)
                        conv_cnt <= conv_cnt + acs_pkg::LEN_W'(1);
            endcase
        end
    end

    // ready high for one sampling period after completion
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ready <= 1'b0;
        else if (conv_done)
            ready <= 1'b1;
        else if (fs_tick || !osc_run)
            ready <= 1'b0;
    end

    // amplifier settling status after config write
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            settle_cnt <= '0;
        else if (acfg_wr)
            settle_cnt <= 11'(11'h1 << osr_log2);
        else if (fs_tick && settle_cnt != 11'h0)
            settle_cnt <= settle_cnt - 11'h1;
    end

    assign settled = bypass || settle_cnt == 11'h0;

    // interrupts: sticky, set wins over clear
    assign irq_event = {started && !started_q, scl_to && !scl_to_q, conv_done};

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_stat <= '0;
        else
            irq_stat <= (irq_stat & ~irq_clr) | irq_event;
    end

    assign irq = |(irq_stat & irq_mask);
endmodule

// [tb/acs_sequencer_assertions.sv]
`timescale 1ns/1ps
// port checks for the conversion sequencer
module acs_sva #(
    parameter int FS_DIV = 4,
    parameter int SCLTO_CYCLES = 50
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pin and outputs
    input wire logic scl_in,
    input wire logic ready,
    input wire logic pga_reset,
    input wire logic serial_if_rst,
    input wire logic [2:0] amplifier_bias_quarters
);
    logic [7:0] aw_a; // last write address
    logic w_ok; // last low strobe
    logic [1:0] scl_s; // own pin synchroniser
    int lo_n; // cycles pin low
    int rd_n; // cycles ready high
    logic cfg; // analog config hit
    logic bad; // unmapped hit
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    assign cfg = w_ok && aw_a[7:2] >= 6'h3 && aw_a[7:2] <= 6'h7;
    assign bad = aw_a[7:2] > 6'hb;
    // tracks writes, pin low time and pulse width
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_a <= 8'h00;
            w_ok <= 1'b0;
            scl_s <= 2'h3;
            lo_n <= 0;
            rd_n <= 0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready) aw_a <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) w_ok <= s_axi_wstrb[0];
            scl_s <= {scl_s[0], scl_in};
            lo_n <= scl_s[1] ? 0 : lo_n + 1;
            rd_n <= ready ? rd_n + 1 : 0;
        end
    end
    // a write has just been answered
    sequence s_wr_done;
        $rose(s_axi_bvalid);
    endsequence
    // that write went to analog config
    sequence s_cfg_wr;
        s_wr_done ##0 cfg;
    endsequence
    a_pga_after_cfg: assert property (s_cfg_wr |-> ##[0:1] pga_reset)
        else $error("no amplifier reset after config write");
    a_pga_one_pulse: assert property (pga_reset |=> !pga_reset)
        else $error("amplifier reset too long");
    a_ready_width: assert property ($fell(ready) |-> rd_n == FS_DIV)
        else $error("ready pulse width wrong");
    a_sclto_low_time: assert property (serial_if_rst |-> lo_n >= SCLTO_CYCLES)
        else $error("serial reset too early");
    a_sclto_one_pulse: assert property (serial_if_rst |=> !serial_if_rst)
        else $error("serial reset too long");
    a_bias_on_write: assert property ($changed(amplifier_bias_quarters) |->
        s_axi_bvalid && amplifier_bias_quarters inside {[3'h1:3'h4]})
        else $error("bias changed without write");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_bresp_code: assert property (s_wr_done |-> s_axi_bresp == (bad ? 2'h2 : 2'h0))
        else $error("write response code wrong");
endmodule

bind acs_sequencer acs_sva #(.FS_DIV(FS_DIV), .SCLTO_CYCLES(SCLTO_CYCLES)) u_sva (
    .core_clk(core_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .scl_in(scl_in), .ready(ready),
    .pga_reset(pga_reset), .serial_if_rst(serial_if_rst),
    .amplifier_bias_quarters(amplifier_bias_quarters));

// [tb/acs_scl_host.sv]
`timescale 1ns/1ps
// host end of the bus clock line
module acs_scl_host (
    // clock
    input wire logic core_clk,
    // bench controls
    input wire logic active,
    input wire logic stall,
    // bus clock line
    output logic scl
);
    logic [3:0] div = 4'h0; // top bit toggles every eight clocks
    always_ff @(posedge core_clk)
        div <= div + 4'h1;
    // stall holds low, idle leaves the pull-up
    assign scl = !stall && (!active || div[3]);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
// bench for the conversion sequencer
module tb_top;
    localparam int FS = 4; // clocks per tick
    localparam logic [1:0] OK = 2'h0;
    localparam logic [1:0] SE = 2'h2;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, act = 1'b0, stl = 1'b0, rdy_q = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00; // addresses
    logic [31:0] wd = 32'h0, m, rdat; // data
    logic awr, wrd, bv, arr, rv, scl, rdy, sir, osc, irq; // observed
    logic [1:0] bresp, rresp; // answer codes
    logic [3:0] ws = 4'hf; // write strobes
    logic [2:0] ampq, adcq; // bias quarters
    logic [33:0] exp_q[$]; // read notes
    logic [31:0] msk_q[$]; // read masks
    logic [1:0] wexp_q[$]; // write notes
    int nb = 0, nr = 0, nrdy = 0, nsr = 0, cyc = 0, o, l, c; // counters
    int n_errors = 0, tests_run = 0;
    always #10 core_clk = ~core_clk;
    acs_sequencer #(.START_CYCLES(40), .WAKE_CYCLES(20), .SCLTO_CYCLES(50), .FS_DIV(FS)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .scl_in(scl),
        .ready(rdy), .pga_reset(), .serial_if_rst(sir), .osc_en(osc),
        .amplifier_bias_quarters(ampq), .converter_bias_quarters(adcq), .irq(irq));
    acs_scl_host u_host (.core_clk(core_clk), .active(act), .stall(stl), .scl(scl));
    // compare and count
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // counts, verdict, end
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = nb;
        wexp_q.push_back(e);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        @(posedge core_clk);
        while (nb == n)
        begin
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    // one read, expected value noted under mask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k,
        input logic [1:0] r);
        int n;
        n = nr;
        exp_q.push_back({r, e & k});
        msk_q.push_back(k);
        ara <= a;
        arv <= 1'b1;
        @(posedge core_clk);
        while (nr == n)
        begin
            if (arr) arv <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    // waits for k new ready pulses
    task automatic wait_rdy(input int k);
        int t;
        t = nrdy;
        c = 0;
        while (nrdy < t + k)
        begin
            @(posedge core_clk);
            c++;
        end
    endtask
    // answers against oldest notes, event counts, timeout
    always @(posedge core_clk)
    begin
        if (bv)
        begin
            chk({32'h0, bresp}, {32'h0, wexp_q.pop_front()});
            nb <= nb + 1;
        end
        if (rv)
        begin
            m = msk_q.pop_front();
            chk({rresp, rdat & m}, exp_q.pop_front());
            nr <= nr + 1;
        end
        rdy_q <= rdy;
        if (rdy && !rdy_q) nrdy <= nrdy + 1;
        if (sir) nsr <= nsr + 1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h87b7));
        tk(20);
        rst_b <= 1'b1;
        rd(8'h00, 32'h08, 32'h3f, OK);
        rd(8'h04, 32'h13, 32'hff, OK);
        rd(8'h08, 32'h0f, 32'h0f, OK);
        rd(8'h20, 32'h600, 32'h1f02, OK);
        tk(40);
        rd(8'h20, 32'h6, 32'h6, OK);
        rd(8'h24, 32'h4, 32'h7, OK);
        chk(34'(irq), 34'h0);
        wr(8'h28, 32'h7, OK);
        chk(34'(irq), 34'h1);
        wr(8'h24, 32'h4, OK);
        chk(34'(irq), 34'h0);
        // every bias code on both fields
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h08, {28'h0, 2'(i), 2'(3 - i)}, OK);
            chk(34'(ampq), 34'(4 - i));
            chk(34'(adcq), 34'(i + 1));
        end
        ws <= 4'($urandom) & 4'he;
        wr(8'h08, 32'h0, OK);
        ws <= 4'hf;
        chk(34'(ampq), 34'h1);
        // refused and boundary settings
        wr(8'h04, 32'h12, OK);
        wr(8'h04, 32'h1b, OK);
        wr(8'h04, 32'h33, OK);
        rd(8'h04, 32'h13, 32'hff, OK);
        wr(8'h04, 32'h1a, OK);
        rd(8'h20, 32'h1400, 32'h1f00, OK);
        // one conversion per count
        for (int i = 0; i < 4; i++)
        begin
            o = $urandom_range(4, 3);
            l = (1 << i) * ((1 << o) + 1) + 1;
            wr(8'h04, {24'h0, 4'(1 << i), 4'(o)}, OK);
            wr(8'h0c + 8'(4 * i), $urandom & 32'hff, OK);
            rd(8'h20, 32'h0, 32'h8, OK);
            tk((1 << o) * FS + FS);
            rd(8'h20, {19'h0, 5'(2 * o + i), 8'h8}, 32'h1f08, OK);
            wr(8'h00, 32'h9, OK);
            wait_rdy(1);
            chk(34'(c >= (l - 1) * FS - 3 && c <= l * FS + 3), 34'h1);
            rd(8'h2c, l, 32'hffffffff, OK);
        end
        chk(34'(irq), 34'h1);
        wr(8'h24, 32'h7, OK);
        chk(34'(irq), 34'h0);
        // continuous mode rearms
        wr(8'h00, 32'hb, OK);
        wait_rdy(2);
        chk(34'(c <= 2 * l * FS + 8), 34'h1);
        wr(8'h00, 32'h8, OK);
        wait_rdy(1);
        // bypass needs no settling
        wr(8'h00, 32'hc, OK);
        wr(8'h1c, 32'h3c, OK);
        rd(8'h20, 32'h8, 32'h8, OK);
        wr(8'h00, 32'hd, OK);
        wait_rdy(1);
        // unmapped place
        wr(8'h30, 32'h1, SE);
        rd(8'h30, 32'h0, 32'hffffffff, SE);
        // bus clock low timeout on, then off
        act <= 1'b1;
        tk(100);
        chk(34'(nsr), 34'h0);
        stl <= 1'b1;
        tk(60);
        stl <= 1'b0;
        tk(4);
        chk(34'(nsr), 34'h1);
        rd(8'h24, 32'h2, 32'h2, OK);
        wr(8'h00, 32'h0, OK);
        stl <= 1'b1;
        tk(60);
        stl <= 1'b0;
        tk(4);
        chk(34'(nsr), 34'h1);
        act <= 1'b0;
        // sleep and wake
        wr(8'h00, 32'h28, OK);
        chk(34'(osc), 34'h0);
        wr(8'h28, 32'h7, OK);
        chk(34'(osc), 34'h1);
        rd(8'h20, 32'h0, 32'h4, OK);
        tk(20);
        rd(8'h20, 32'h4, 32'h4, OK);
        // soft reset reruns startup
        wr(8'h00, 32'h10, OK);
        rd(8'h20, 32'h0, 32'h2, OK);
        rd(8'h00, 32'h8, 32'h2e, OK);
        tk(40);
        rd(8'h20, 32'h2, 32'h2, OK);
        give_verdict();
    end
endmodule
